// ===== bench/scc_ctrl_chk.sv
// assertion checker for the synth startup control ports
`timescale 1ns/1ps
`default_nettype none
module scc_chk (
	input wire logic        i_clk,          // system clock
	input wire logic        i_resetn,       // async reset, active low
	input wire logic        i_osc_stable,   // crystal stable
	input wire logic        i_pll_lock,     // raw lock
	input wire logic        o_osc_en,       // oscillator enable
	input wire logic        o_pll_en,       // pll enable
	input wire logic        o_rx_en,        // receiver enable
	input wire logic        o_tx_en,        // transmitter enable
	input wire logic        o_cal_coarse,   // coarse cal pulse
	input wire logic        o_cal_fine,     // fine cal pulse
	input wire logic [23:0] o_carrier_word, // applied word
	input wire logic        o_carrier_load, // word applied pulse
	input wire logic [2:0]  o_vco_mult,     // vco ratio
	input wire logic        o_aux_pin_five, // clock output
	input wire logic [3:0]  o_dio_lock      // routed lock
);
	// ****************
	// properties
	// ****************
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	coarse_cause_a: assert property (
		o_cal_coarse |-> $past(i_osc_stable))
		else $error("coarse cal without stable crystal");
	coarse_once_a: assert property (
		o_cal_coarse |=> !o_cal_coarse [*8])
		else $error("coarse cal repeated");
	fine_in_pll_a: assert property (
		o_cal_fine |-> o_pll_en && !o_rx_en && !o_tx_en)
		else $error("fine cal outside pll start");
	pll_start_a: assert property (
		$rose(o_pll_en) |-> o_osc_en && o_cal_fine)
		else $error("pll started without osc or fine cal");
	run_needs_pll_a: assert property (
		(o_rx_en || o_tx_en) |-> o_pll_en && !(o_rx_en && o_tx_en))
		else $error("rx or tx without pll");
	word_with_load_a: assert property (
		$changed(o_carrier_word) |-> o_carrier_load)
		else $error("carrier word changed without load");
	load_pulse_a: assert property (
		o_carrier_load |=> !o_carrier_load)
		else $error("carrier load longer than one cycle");
	clk_gate_a: assert property (
		!i_osc_stable [*4] |-> $stable(o_aux_pin_five))
		else $error("clock output toggles before crystal stable");
	clk_low_a: assert property (
		!i_osc_stable |=> !o_aux_pin_five)
		else $error("clock output high without stable crystal");
	sleep_quiet_a: assert property (
		!o_osc_en |=> !o_aux_pin_five)
		else $error("clock output high in sleep");
	vco_code_a: assert property (
		o_vco_mult inside {3'h2, 3'h4, 3'h6})
		else $error("vco ratio not 2 4 or 6");
	lock_route_a: assert property (
		|o_dio_lock |-> $past(i_pll_lock) && $onehot(o_dio_lock))
		else $error("lock routed without lock");
	cov_load: cover property (o_carrier_load);
	cov_fine: cover property (o_cal_fine);
	cov_tx: cover property (o_tx_en);
	cov_rx: cover property (o_rx_en);
endmodule // scc_chk
bind scc_ctrl scc_chk u_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_osc_stable(i_osc_stable),
	.i_pll_lock(i_pll_lock), .o_osc_en(o_osc_en), .o_pll_en(o_pll_en), .o_rx_en(o_rx_en),
	.o_tx_en(o_tx_en), .o_cal_coarse(o_cal_coarse), .o_cal_fine(o_cal_fine),
	.o_carrier_word(o_carrier_word), .o_carrier_load(o_carrier_load),
	.o_vco_mult(o_vco_mult), .o_aux_pin_five(o_aux_pin_five), .o_dio_lock(o_dio_lock));
`default_nettype wire

// ===== bench/scc_ctrl_tb.sv
// self-checking bench for the synth startup control block
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.vh"
module scc_ctrl_tb;
	logic        clk, rstn, sck, mosi, nss_n, miso, oe_n, osc_ok, lock;
	logic        osc_en, pll_en, rx_en, tx_en, cal_c, cal_f, load, aux;
	logic [23:0] word;
	logic [2:0]  vco;
	logic [3:0]  dio;
	logic [7:0]  q;
	int          err_count, checks_done, n_load, n_fine, n_coarse, i;
	logic        a0;
	logic [10:0] rows [4] = '{{8'h04, 3'h2}, {8'h05, 3'h4}, {8'h06, 3'h6}, {8'h07, 3'h2}};
	// undriven miso shows the inverse so a stale bit cannot pass
	wire         miso_w = oe_n ? ~miso : miso;
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	scc_ctrl dut (.i_clk(clk), .i_resetn(rstn), .i_sck(sck), .i_mosi(mosi), .i_nss_n(nss_n),
		.o_miso(miso), .o_miso_oe_n(oe_n), .i_osc_stable(osc_ok), .i_pll_lock(lock),
		.o_osc_en(osc_en), .o_pll_en(pll_en), .o_rx_en(rx_en), .o_tx_en(tx_en),
		.o_cal_coarse(cal_c), .o_cal_fine(cal_f), .o_carrier_word(word),
		.o_carrier_load(load), .o_vco_mult(vco), .o_aux_pin_five(aux), .o_dio_lock(dio));
	scc_host host (.i_clk(clk), .i_miso(miso_w), .o_sck(sck), .o_mosi(mosi), .o_nss_n(nss_n));
	// count one-cycle pulses
	always @(posedge clk) begin
		if (load === 1'b1) n_load++;
		if (cal_f === 1'b1) n_fine++;
		if (cal_c === 1'b1) n_coarse++;
	end
	task automatic chk(input logic [31:0] seen, exp, input string nm);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// bounded wait for aux (0) or tx enable (1) to go high
	task automatic wait_hi(input int sel, lim, input string nm);
		int n;
		n = 0;
		while (((sel == 1) ? tx_en : aux) !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
		if (n >= lim) begin
			err_count++;
			$display("[ERR] %s expected 1 seen 0", nm);
			end_of_test();
		end
	endtask
	initial begin
		rstn = 1'b0;
		osc_ok = 1'b0;
		lock = 1'b0;
		repeat (6) @(negedge clk);
		chk({osc_en, pll_en, rx_en, tx_en, aux}, 5'h10, "reset outputs");
		chk({word, vco}, 27'h2, "reset word vco");
		chk({oe_n, miso, cal_c, cal_f, load, dio}, 9'h100, "reset spi cal");
		rstn = 1'b1;
		repeat (20) @(negedge clk);
		chk(aux, 1'b0, "clock before crystal");
		chk(n_coarse, 8'h0, "coarse before crystal");
		osc_ok = 1'b1;
		// host watches the clock output within the wake-up allowance
		wait_hi(0, `SCC_OSC_WAKE_CYC, "clock out");
		a0 = aux;
		@(negedge clk);
		chk(aux, !a0, "clock out half rate");
		chk(n_coarse, 8'h1, "coarse once");
		$display("test reset done");
		for (i = 0; i < 4; i++) begin
			host.xfer(8'h81, rows[i][10:3], q);
			host.xfer(8'h01, 8'h00, q);
			chk(q, rows[i][10:3], "opmode read");
			chk(vco, rows[i][2:0], "vco ratio");
		end
		host.xfer(8'h81, 8'h04, q);
		host.xfer(8'h87, 8'h12, q);
		host.xfer(8'h88, 8'h34, q);
		chk(word, 24'h0, "word pending");
		chk(n_load, 8'h0, "no early load");
		host.xfer(8'h89, 8'h56, q);
		chk(word, 24'h12_3456, "carrier word");
		chk(n_load, 8'h1, "load pulses");
		host.xfer(8'h07, 8'h00, q);
		chk(q, 8'h12, "high byte read");
		host.xfer(8'h7f, 8'h00, q);
		chk(q, 8'h00, "unmapped read");
		host.xfer(8'h27, 8'h00, q);
		chk(q, 8'h12, "status standby");
		$display("test registers done");
		host.xfer(8'h81, 8'h0c, q);
		chk({pll_en, tx_en}, 2'h2, "tx waits lock");
		chk(n_fine, 8'h1, "fine cal");
		lock = 1'b1;
		// host waits for the enable within the synth allowance
		wait_hi(1, `SCC_SYN_WAKE_CYC, "tx enable");
		lock = 1'b0;
		repeat (4) @(negedge clk);
		chk(tx_en, 1'b1, "tx across unlock");
		lock = 1'b1;
		// clock output turned off while lock goes to pin one
		host.xfer(8'ha6, 8'h57, q);
		chk(dio, 4'h2, "lock route");
		chk(aux, 1'b0, "clock out off code");
		host.xfer(8'h81, 8'h10, q);
		chk({rx_en, tx_en}, 2'h2, "rx mode");
		// sequencer off: tx starts with no lock, the host owns the timing
		lock = 1'b0;
		host.xfer(8'h81, 8'h84, q);
		chk({pll_en, rx_en, tx_en}, 3'h0, "standby seq off");
		host.xfer(8'h81, 8'h8c, q);
		chk(tx_en, 1'b1, "manual tx no lock");
		chk(n_fine, 8'h2, "fine per start");
		host.xfer(8'h81, 8'h08, q);
		host.xfer(8'h27, 8'h00, q);
		chk(q, 8'h13, "status synth only");
		chk(n_fine, 8'h3, "fine again");
		host.xfer(8'h81, 8'h00, q);
		chk({osc_en, pll_en, rx_en}, 3'h0, "sleep");
		$display("test sequencer done");
		// reset in mid-run, crystal already stable
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		chk({osc_en, word}, 25'h100_0000, "mid reset");
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		chk(n_coarse, 8'h2, "coarse after reset");
		a0 = aux;
		@(negedge clk);
		chk(aux, !a0, "clock out after reset");
		host.xfer(8'h27, 8'h00, q);
		chk(q, 8'h12, "status after reset");
		$display("test mid reset done");
		end_of_test();
	end
endmodule // scc_ctrl_tb
`default_nettype wire

// ===== bench/scc_host.sv
// host side spi master model for the register port
`timescale 1ns/1ps
`default_nettype none
module scc_host (
	input  wire logic i_clk,   // system clock
	input  wire logic i_miso,  // resolved read data line
	output var  logic o_sck,   // spi clock, idle low
	output var  logic o_mosi,  // spi data out
	output var  logic o_nss_n  // spi select, active low
);
	// idle: deselected, clock parked low
	initial begin
		o_sck = 1'b0;
		o_mosi = 1'b0;
		o_nss_n = 1'b1;
	end
	// one byte msb first; sck low and high three cycles each, so the
	// 50 ns high and low minimums and the 10 MHz ceiling are kept
	task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx);
		for (int b = 7; b >= 0; b--) begin
			@(negedge i_clk);
			o_sck = 1'b0;
			o_mosi = tx[b];
			@(negedge i_clk);
			@(negedge i_clk);
			@(negedge i_clk);
			rx[b] = i_miso;
			o_sck = 1'b1;
			@(negedge i_clk);
			@(negedge i_clk);
		end
	endtask
	// address byte then one data byte; mosi flips once released
	task automatic xfer(input logic [7:0] a, d, output logic [7:0] q);
		logic [7:0] junk;
		@(negedge i_clk);
		o_nss_n = 1'b0;
		byte_x(a, junk);
		byte_x(d, q);
		@(negedge i_clk);
		o_sck = 1'b0;
		// select held two cycles past the last falling clock edge
		repeat (2) @(negedge i_clk);
		o_nss_n = 1'b1;
		o_mosi = ~o_mosi;
		repeat (2) @(negedge i_clk);
	endtask
endmodule // scc_host
`default_nettype wire

// ===== core/scc_ctrl.v
// synthesizer startup sequencer, carrier word registers and spi register port
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.vh"

module scc_ctrl (
	input  wire        i_clk,          // crystal derived clock
	input  wire        i_resetn,       // async reset, active low
	input  wire        i_sck,          // spi clock
	input  wire        i_mosi,         // spi data in
	input  wire        i_nss_n,        // spi select, active low
	output wire        o_miso,         // spi data out
	output wire        o_miso_oe_n,    // miso drive enable, active low
	input  wire        i_osc_stable,   // crystal oscillation detected stable
	input  wire        i_pll_lock,     // raw lock from the pll
	output wire        o_osc_en,       // crystal oscillator enable
	output wire        o_pll_en,       // pll enable
	output wire        o_rx_en,        // receiver enable
	output wire        o_tx_en,        // transmitter enable
	output reg         o_cal_coarse,   // coarse vco calibration pulse
	output reg         o_cal_fine,     // fine vco calibration pulse
	output reg  [23:0] o_carrier_word, // word applied to synthesizer
	output reg         o_carrier_load, // pulse when word applied
	output reg  [2:0]  o_vco_mult,     // vco to carrier ratio
	output wire        o_aux_pin_five, // reference clock output
	output reg  [3:0]  o_dio_lock      // lock indicator per dio pin
);

	// ****************************************
	// sequencer states
	// ****************************************
	localparam [2:0] ST_SLEEP = 3'h0;
	localparam [2:0] ST_OSC   = 3'h1;
	localparam [2:0] ST_STBY  = 3'h2;
	localparam [2:0] ST_PLL   = 3'h3;
	localparam [2:0] ST_RUN   = 3'h4;

	reg [7:0] opmode_r;
	reg [7:0] frf_high_r;
	reg [7:0] frf_mid_r;
	reg [7:0] frf_low_r;
	reg [7:0] pinmap2_r;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg       coarse_done_r;
	reg       sck_q_r;
	reg [2:0] bitcnt_r;
	reg [6:0] shift_r;
	reg [7:0] tx_r;
	reg [6:0] addr_r;
	reg       wnr_r;
	reg       first_r;

	wire [2:0] mode    = opmode_r[`SCC_OPM_MODE_HI:`SCC_OPM_MODE_LO];
	wire       seq_off = opmode_r[`SCC_OPM_SEQ_OFF];
	wire       want_fs = (mode == `SCC_MODE_FS) || (mode == `SCC_MODE_TX) ||
	                     (mode == `SCC_MODE_RX);
	wire       want_tr = (mode == `SCC_MODE_TX) || (mode == `SCC_MODE_RX);

	// ****************************************
	// spi edge detect and byte assembly
	// ****************************************
	wire       sck_rise = i_sck & ~sck_q_r & ~i_nss_n;
	wire       sck_fall = ~i_sck & sck_q_r & ~i_nss_n;
	wire       byte_end = sck_rise && (bitcnt_r == 3'h7);
	wire [7:0] byte_in  = {shift_r, i_mosi};
	wire       wr_stb   = byte_end && !first_r && wnr_r;
	wire [6:0] next_rd  = first_r ? byte_in[6:0] : (addr_r + 7'h01);

	// read decode, used for the spi load and nothing clever
	function [7:0] rd_mux;
		input [6:0] a;
		begin
			case (a)
				`SCC_ADDR_OPMODE:   rd_mux = opmode_r;
				`SCC_ADDR_FRF_HIGH: rd_mux = frf_high_r;
				`SCC_ADDR_FRF_MID:  rd_mux = frf_mid_r;
				`SCC_ADDR_FRF_LOW:  rd_mux = frf_low_r;
				`SCC_ADDR_PINMAP2:  rd_mux = pinmap2_r;
				`SCC_ADDR_STATUS:   rd_mux = {3'h0, i_osc_stable, i_pll_lock,
				                              state_r};
				default:            rd_mux = 8'h00;
			endcase
		end
	endfunction

	// spi slave: first byte is direction and address, then burst data
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sck_q_r  <= 1'b0;
			bitcnt_r <= 3'h0;
			shift_r  <= 7'h00;
			tx_r     <= 8'h00;
			addr_r   <= 7'h00;
			wnr_r    <= 1'b0;
			first_r  <= 1'b1;
		end else begin
			sck_q_r <= i_sck;
			if (i_nss_n) begin
				bitcnt_r <= 3'h0;
				first_r  <= 1'b1;
			end else if (sck_rise) begin
				shift_r  <= byte_in[6:0];
				bitcnt_r <= bitcnt_r + 3'h1;
				if (byte_end) begin
					// address auto increments across a burst
					addr_r  <= next_rd;
					tx_r    <= rd_mux(next_rd);
					first_r <= 1'b0;
					if (first_r)
						wnr_r <= byte_in[7];
				end
			end else if (sck_fall && (bitcnt_r != 3'h0)) begin
				// no shift right after a load, so the msb survives
				tx_r <= {tx_r[6:0], 1'b0};
			end
		end
	end

	assign o_miso      = tx_r[7];
	assign o_miso_oe_n = i_nss_n | wnr_r | first_r;

	// ****************************************
	// register writes
	// ****************************************
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			opmode_r       <= `SCC_RST_OPMODE;
			frf_high_r     <= `SCC_RST_FRF_HIGH;
			frf_mid_r      <= `SCC_RST_FRF_MID;
			frf_low_r      <= `SCC_RST_FRF_LOW;
			pinmap2_r      <= `SCC_RST_PINMAP2;
			o_carrier_word <= {`SCC_RST_FRF_HIGH, `SCC_RST_FRF_MID, `SCC_RST_FRF_LOW};
			o_carrier_load <= 1'b0;
		end else begin
			o_carrier_load <= 1'b0;
			if (wr_stb) begin
				case (addr_r)
					`SCC_ADDR_OPMODE:   opmode_r  <= byte_in;
					// [RULE_02] upper carrier bytes
					// [RULE_03] held pending only
					`SCC_ADDR_FRF_HIGH: frf_high_r <= byte_in;
					`SCC_ADDR_FRF_MID:  frf_mid_r  <= byte_in;
					`SCC_ADDR_FRF_LOW: begin
						frf_low_r <= byte_in;
						// [RULE_03] apply on low byte
						// [RULE_01] step times word
						o_carrier_word <= {frf_high_r, frf_mid_r, byte_in};
						o_carrier_load <= 1'b1;
					end
					`SCC_ADDR_PINMAP2:  pinmap2_r <= byte_in;
					default: ;
				endcase
			end
		end
	end

	// ****************************************
	// startup sequencer next state
	// ****************************************
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_SLEEP: if (mode != `SCC_MODE_SLEEP) state_nxt = ST_OSC;
			ST_OSC: begin
				if (mode == `SCC_MODE_SLEEP)
					state_nxt = ST_SLEEP;
				else if (i_osc_stable)
					state_nxt = ST_STBY;
			end
			ST_STBY: begin
				// [RULE_04] pll starts on stable
				if (mode == `SCC_MODE_SLEEP)
					state_nxt = ST_SLEEP;
				else if (want_fs)
					state_nxt = ST_PLL;
			end
			ST_PLL: begin
				// [RULE_12] rx or tx after lock
				if (!want_fs)
					state_nxt = (mode == `SCC_MODE_SLEEP) ? ST_SLEEP : ST_STBY;
				else if (want_tr && (i_pll_lock || seq_off))
					state_nxt = ST_RUN;
			end
			ST_RUN: begin
				// [RULE_15] lock drop tolerated here
				if (!want_tr)
					state_nxt = (mode == `SCC_MODE_SLEEP) ? ST_SLEEP : ST_STBY;
			end
			default: state_nxt = ST_SLEEP;
		endcase
	end

	// state register and calibration pulses
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r       <= ST_OSC;
			coarse_done_r <= 1'b0;
			o_cal_coarse  <= 1'b0;
			o_cal_fine    <= 1'b0;
		end else begin
			state_r <= state_nxt;
			// [RULE_11] coarse once after reset
			o_cal_coarse <= i_osc_stable && !coarse_done_r;
			if (i_osc_stable)
				coarse_done_r <= 1'b1;
			// [RULE_11] fine on each pll start
			o_cal_fine <= (state_nxt == ST_PLL) && (state_r != ST_PLL);
		end
	end

	// manual mode skips the lock wait; the host owns the timing then
	assign o_osc_en = (state_r != ST_SLEEP);
	assign o_pll_en = (state_r == ST_PLL) || (state_r == ST_RUN);
	assign o_rx_en  = (state_r == ST_RUN) && (mode == `SCC_MODE_RX);
	assign o_tx_en  = (state_r == ST_RUN) && (mode == `SCC_MODE_TX);

	// ****************************************
	// vco ratio and lock routing
	// ****************************************
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_vco_mult <= `SCC_VCO_X2;
			o_dio_lock <= 4'h0;
		end else begin
			// [RULE_10] ratio from band
			case (opmode_r[`SCC_OPM_BAND_HI:`SCC_OPM_BAND_LO])
				`SCC_BAND_915: o_vco_mult <= `SCC_VCO_X2;
				`SCC_BAND_434: o_vco_mult <= `SCC_VCO_X4;
				`SCC_BAND_315: o_vco_mult <= `SCC_VCO_X6;
				default:       o_vco_mult <= `SCC_VCO_X2;
			endcase
			// [RULE_14] lock routed to pin
			o_dio_lock <= 4'h0;
			if (pinmap2_r[`SCC_PM2_LOCK_EN])
				o_dio_lock[pinmap2_r[`SCC_PM2_LOCK_HI:`SCC_PM2_LOCK_LO]] <=
					i_pll_lock && o_pll_en;
		end
	end

	// ****************************************
	// reference clock output
	// ****************************************
	// [RULE_07] divided reference on pin
	// [RULE_08] off in sleep, before crystal stable and at code seven
	scc_ref_clock_output #(
		.CW (7)
	) u_ref_clock_output (
		.i_clk     (i_clk),
		.i_resetn  (i_resetn),
		.i_enable  (i_osc_stable && (state_r != ST_SLEEP)),
		.i_sel     (pinmap2_r[`SCC_PM2_CLK_HI:`SCC_PM2_CLK_LO]),
		.o_clk_out (o_aux_pin_five)
	);

endmodule // scc_ctrl

`default_nettype wire

// ===== core/scc_map.vh
// register map, field positions and timing constants for the synth startup control
// Functional notes
// [RULE_01] carrier equals crystal over 2^19 times word
// [RULE_02] carrier word in bytes 0x07 to 0x09
// [RULE_03] upper bytes pend until low byte written
// [RULE_04] sequencer starts pll once crystal stable
// [RULE_05] clock output gated until crystal stable
// [RULE_06] manual host waits oscillator time or clock
// [RULE_07] aux pin five carries divided reference
// [RULE_08] clock out all modes but sleep, on
// [RULE_09] host disables clock output when unused
// [RULE_10] vco runs 2, 4, 6 times carrier
// [RULE_11] coarse cal at reset, fine per pll
// [RULE_12] sequencer starts rx or tx after lock
// [RULE_13] manual host waits synth time or lock
// [RULE_14] lock high in range, routable to pins
// [RULE_15] lock may drop during wide fsk
// [RULE_16] oscillator wake-up allowance 500 us
// [RULE_17] synthesizer wake-up allowance 150 us
// [RULE_18] clock out divider encoding from pin map
`ifndef SCC_MAP_VH
`define SCC_MAP_VH

// ****************************************
// register addresses
// ****************************************
`define SCC_ADDR_OPMODE   7'h01
`define SCC_ADDR_FRF_HIGH 7'h07
`define SCC_ADDR_FRF_MID  7'h08
`define SCC_ADDR_FRF_LOW  7'h09
`define SCC_ADDR_PINMAP2  7'h26
`define SCC_ADDR_STATUS   7'h27

// ****************************************
// reset values
// ****************************************
`define SCC_RST_OPMODE    8'h04
`define SCC_RST_FRF_HIGH  8'h00
`define SCC_RST_FRF_MID   8'h00
`define SCC_RST_FRF_LOW   8'h00
`define SCC_RST_PINMAP2   8'h00

// ****************************************
// field positions
// ****************************************
`define SCC_OPM_SEQ_OFF   7
`define SCC_OPM_MODE_HI   4
`define SCC_OPM_MODE_LO   2
`define SCC_OPM_BAND_HI   1
`define SCC_OPM_BAND_LO   0
`define SCC_PM2_CLK_HI    2
`define SCC_PM2_CLK_LO    0
`define SCC_PM2_LOCK_HI   5
`define SCC_PM2_LOCK_LO   4
`define SCC_PM2_LOCK_EN   6

// ****************************************
// encodings
// ****************************************
`define SCC_MODE_SLEEP    3'h0
`define SCC_MODE_STBY     3'h1
`define SCC_MODE_FS       3'h2
`define SCC_MODE_TX       3'h3
`define SCC_MODE_RX       3'h4
`define SCC_BAND_915      2'h0
`define SCC_BAND_434      2'h1
`define SCC_BAND_315      2'h2
`define SCC_VCO_X2        3'h2
`define SCC_VCO_X4        3'h4
`define SCC_VCO_X6        3'h6
`define SCC_CLK_OFF       3'h7

// ****************************************
// timing, host side wake-up allowances
// ****************************************
`define SCC_CLK_MHZ       50
`define SCC_STEP_SHIFT    19
`define SCC_OSC_WAKE_US   500
`define SCC_SYN_WAKE_US   150
`define SCC_OSC_WAKE_CYC  (`SCC_OSC_WAKE_US * `SCC_CLK_MHZ)
`define SCC_SYN_WAKE_CYC  (`SCC_SYN_WAKE_US * `SCC_CLK_MHZ)

`endif

// ===== core/scc_ref_clock_output.v
// reference clock output divider for the aux pin
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.vh"

module scc_ref_clock_output #(
	parameter CW = 7
) (
	input  wire       i_clk,      // reference clock
	input  wire       i_resetn,   // async reset, active low
	input  wire       i_enable,   // crystal stable and not sleeping
	input  wire [2:0] i_sel,      // divider select field
	output wire       o_clk_out   // divided clock, registered
);

	reg [CW-1:0] cnt_r;
	reg          out_r;

	// ****************************************
	// free running divider
	// ****************************************
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_r <= {CW{1'b0}};
			out_r <= 1'b0;
		end else begin
			cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
			// [RULE_05] gated until stable
			// [RULE_18] code seven is off
			if (i_enable && (i_sel != `SCC_CLK_OFF))
				out_r <= cnt_r[i_sel];   // divide by 2 to the sel plus one
			else
				out_r <= 1'b0;           // held low, no glitch into the pin
		end
	end

	assign o_clk_out = out_r;

endmodule // scc_ref_clock_output

`default_nettype wire
